// [output_regulation_control_regs.sv]
// Output regulation register bank with gate sequencing and fault flags
//
// The register offsets and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module output_regulation_control_regs
  import vreg_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        arst_n_in,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [3:0]  avs_byteenable_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Analog comparators and zero detect
  input  wire logic        vout_below_uv_in,
  input  wire logic        vout_above_ov_in,
  input  wire logic        low_side_zero_in,
  // Switching cycle timing, same clock
  input  wire logic        cycle_start_in,
  input  wire logic        duty_end_in,
  // Reference and threshold DACs
  output logic             setpoint_dac_enable_out,
  output logic      [7:0]  coarse_code_out,
  output logic      [4:0]  fine_code_out,
  output logic      [21:0] vref_uv_out,
  output logic             overvoltage_detect_en_out,
  output logic             undervoltage_detect_en_out,
  output logic      [11:0] uv_threshold_mv_out,
  output logic      [11:0] ov_threshold_mv_out,
  // Power stage
  output logic             high_gate_drive_out,
  output logic             low_gate_drive_out,
  output logic             high_drive_1a_out,
  output logic             high_dead_time_add_out,
  output logic             low_dead_time_add_out,
  output logic             pos_sense_pullup_out,
  output logic             neg_sense_pulldown_out,
  // Fault flags
  output logic             undervoltage_flag_out,
  output logic             overvoltage_flag_out
);

  // Register storage
  logic [7:0]  coarse_r;
  logic [7:0]  fine_r;
  logic [7:0]  uv_level_r;
  logic [7:0]  ov_level_r;
  periph_ctl_t periph_r;
  logic [7:0]  abe_r;
  logic        uv_flag_r;
  logic        ov_flag_r;

  // Bus handshake
  logic        wait_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        wr_take;
  logic        rd_take;
  logic        wr_lo;

  // Synchronisers
  logic [2:0]  uv_sync_r;
  logic [2:0]  ov_sync_r;
  logic [2:0]  zero_sync_r;
  logic        uv_lvl_r;
  logic        ov_lvl_r;
  logic        zero_lvl_r;

  // Derived conditions
  logic        uv_en;
  logic        ov_en;
  logic        uv_fault;
  logic        ov_fault;
  logic        force_low;

  // Gate sequencing
  phase_t      phase_r;
  phase_t      phase_nxt;
  gate_pair_t  gate_r;
  gate_pair_t  gate_nxt;

  // DAC outputs
  logic [21:0] vref_nxt;

  assign wr_take = avs_write_in && !wait_r;
  assign rd_take = avs_read_in && wait_r;
  assign wr_lo   = wr_take && avs_byteenable_in[0];

  // One wait cycle per access, then answer
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wait_r <= 1'b1;
    end else if (wait_r && (avs_read_in || avs_write_in)) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= 1'b1;
    end
  end

  // Read mux, unmapped addresses read zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (avs_address_in)
      OFS_COARSE: begin
        rdata_nxt[7:0] = coarse_r;
      end
      OFS_FINE: begin
        rdata_nxt[FINE_EN_BIT] = fine_r[FINE_EN_BIT];
        rdata_nxt[FINE_MSB:0]  = fine_r[FINE_MSB:0];
      end
      OFS_UV_LEVEL: begin
        rdata_nxt[7:0] = uv_level_r;
      end
      OFS_OV_LEVEL: begin
        rdata_nxt[7:0] = ov_level_r;
      end
      OFS_PERIPH: begin
        rdata_nxt[7:0] = periph_r;
      end
      OFS_ABE: begin
        rdata_nxt[7:0] = abe_r;
      end
      OFS_FLAGS: begin
        rdata_nxt[FLAG_UV_BIT] = uv_flag_r;
        rdata_nxt[FLAG_OV_BIT] = ov_flag_r;
      end
      default: begin
        rdata_nxt = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_r <= rdata_nxt;
    end
  end

  // Configuration writes
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      coarse_r   <= RST_COARSE;
      fine_r     <= RST_FINE;
      uv_level_r <= RST_UV_LEVEL;
      ov_level_r <= RST_OV_LEVEL;
      periph_r   <= periph_ctl_t'(RST_PERIPH);
      abe_r      <= RST_ABE;
    end else if (wr_lo) begin
      unique case (avs_address_in)
        OFS_COARSE: begin
          coarse_r <= avs_writedata_in[7:0];
        end
        OFS_FINE: begin
          fine_r <= avs_writedata_in[7:0] & 8'h9F;
        end
        OFS_UV_LEVEL: begin
          uv_level_r <= avs_writedata_in[7:0];
        end
        OFS_OV_LEVEL: begin
          ov_level_r <= avs_writedata_in[7:0];
        end
        OFS_PERIPH: begin
          periph_r <= periph_ctl_t'(avs_writedata_in[7:0]);
        end
        OFS_ABE: begin
          abe_r <= avs_writedata_in[7:0];
        end
        default: begin
          abe_r <= abe_r;
        end
      endcase
    end
  end

  // Comparator inputs through three flops
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      uv_sync_r   <= 3'h0;
      ov_sync_r   <= 3'h0;
      zero_sync_r <= 3'h0;
    end else begin
      uv_sync_r   <= {uv_sync_r[1:0], vout_below_uv_in};
      ov_sync_r   <= {ov_sync_r[1:0], vout_above_ov_in};
      zero_sync_r <= {zero_sync_r[1:0], low_side_zero_in};
    end
  end

  // Level changes once stages two and three agree
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      uv_lvl_r   <= 1'b0;
      ov_lvl_r   <= 1'b0;
      zero_lvl_r <= 1'b0;
    end else begin
      if (uv_sync_r[1] == uv_sync_r[2]) begin
        uv_lvl_r <= uv_sync_r[2];
      end
      if (ov_sync_r[1] == ov_sync_r[2]) begin
        ov_lvl_r <= ov_sync_r[2];
      end
      if (zero_sync_r[1] == zero_sync_r[2]) begin
        zero_lvl_r <= zero_sync_r[2];
      end
    end
  end

  assign ov_en    = abe_r[ABE_OV_BIT];
  assign uv_en    = abe_r[ABE_UV_BIT];
  assign ov_fault = ov_en && ov_lvl_r;
  assign uv_fault = uv_en && uv_lvl_r;

  assign force_low = (periph_r.undervoltage_accel_en && uv_fault) ||
                     (periph_r.overvoltage_accel_en && ov_fault);

  // Sticky fault flags
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      uv_flag_r <= 1'b0;
      ov_flag_r <= 1'b0;
    end else begin
      if (uv_fault) begin
        uv_flag_r <= 1'b1;
      end else if (wr_lo && avs_address_in == OFS_FLAGS &&
                   !avs_writedata_in[FLAG_UV_BIT]) begin
        uv_flag_r <= 1'b0;
      end
      if (ov_fault) begin
        ov_flag_r <= 1'b1;
      end else if (wr_lo && avs_address_in == OFS_FLAGS &&
                   !avs_writedata_in[FLAG_OV_BIT]) begin
        ov_flag_r <= 1'b0;
      end
    end
  end

  // Next switching phase
  always_comb begin
    phase_nxt = phase_r;
    unique case (phase_r)
      PH_IDLE: begin
        if (cycle_start_in) begin
          phase_nxt = PH_HIGH;
        end
      end
      PH_HIGH: begin
        if (duty_end_in) begin
          phase_nxt = PH_LOW;
        end
      end
      PH_LOW: begin
        if (cycle_start_in) begin
          phase_nxt = PH_HIGH;
        end else if (periph_r.diode_emulation_select && zero_lvl_r) begin
          phase_nxt = PH_BOTH_LOW;
        end
      end
      PH_BOTH_LOW: begin
        if (cycle_start_in) begin
          phase_nxt = PH_HIGH;
        end
      end
    endcase
    if (force_low) begin
      phase_nxt = PH_BOTH_LOW;
    end
  end

  always_comb begin
    gate_nxt.high_gate_drive = (phase_nxt == PH_HIGH);
    gate_nxt.low_gate_drive  = (phase_nxt == PH_LOW);
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      phase_r <= PH_IDLE;
      gate_r  <= '0;
    end else begin
      phase_r <= phase_nxt;
      gate_r  <= gate_nxt;
    end
  end

  always_comb begin
    vref_nxt = 22'h00_0000;
    if (fine_r[FINE_EN_BIT]) begin
      vref_nxt = 22'(coarse_r * COARSE_STEP_UV) +
                 22'(fine_r[FINE_MSB:0] * FINE_STEP_UV);
    end
  end

  // Analog control outputs
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      setpoint_dac_enable_out    <= 1'b0;
      coarse_code_out            <= 8'h00;
      fine_code_out              <= 5'h00;
      vref_uv_out                <= 22'h00_0000;
      overvoltage_detect_en_out  <= 1'b0;
      undervoltage_detect_en_out <= 1'b0;
      uv_threshold_mv_out        <= 12'h000;
      ov_threshold_mv_out        <= 12'h000;
    end else begin
      setpoint_dac_enable_out <= fine_r[FINE_EN_BIT];
      coarse_code_out <= fine_r[FINE_EN_BIT] ? coarse_r : 8'h00;
      fine_code_out   <= fine_r[FINE_EN_BIT] ?
                         fine_r[FINE_MSB:0] : 5'h00;
      vref_uv_out     <= vref_nxt;
      overvoltage_detect_en_out  <= ov_en;
      undervoltage_detect_en_out <= uv_en;
      uv_threshold_mv_out <= uv_en ?
                             12'(uv_level_r * DETECT_STEP_MV) : 12'h000;
      ov_threshold_mv_out <= ov_en ?
                             12'(ov_level_r * DETECT_STEP_MV) : 12'h000;
    end
  end

  // Driver configuration outputs
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      high_drive_1a_out      <= 1'b0;
      high_dead_time_add_out <= 1'b1;
      low_dead_time_add_out  <= 1'b1;
      pos_sense_pullup_out   <= 1'b0;
      neg_sense_pulldown_out <= 1'b0;
    end else begin
      high_drive_1a_out      <= periph_r.high_drive_strength;
      high_dead_time_add_out <= !periph_r.high_delay_bypass;
      low_dead_time_add_out  <= !periph_r.low_delay_bypass;
      pos_sense_pullup_out   <= periph_r.pos_sense_pullup_en;
      neg_sense_pulldown_out <= periph_r.neg_sense_pulldown_en;
    end
  end

  assign avs_readdata_out      = rdata_r;
  assign avs_waitrequest_out   = wait_r;
  assign high_gate_drive_out   = gate_r.high_gate_drive;
  assign low_gate_drive_out    = gate_r.low_gate_drive;
  assign undervoltage_flag_out = uv_flag_r;
  assign overvoltage_flag_out  = ov_flag_r;

endmodule

`default_nettype wire

// [vreg_ctl_pkg.sv]
// Register map, field layout and constants for output regulation control
package vreg_ctl_pkg;

  // Word offsets on the register bus (byte addresses)
  localparam logic [4:0] OFS_COARSE   = 5'h00;
  localparam logic [4:0] OFS_FINE     = 5'h04;
  localparam logic [4:0] OFS_UV_LEVEL = 5'h08;
  localparam logic [4:0] OFS_OV_LEVEL = 5'h0C;
  localparam logic [4:0] OFS_PERIPH   = 5'h10;
  localparam logic [4:0] OFS_ABE      = 5'h14;
  localparam logic [4:0] OFS_FLAGS    = 5'h18;

  // Field positions
  localparam int FINE_EN_BIT  = 7;
  localparam int FINE_MSB     = 4;
  localparam int ABE_OV_BIT   = 7;
  localparam int ABE_UV_BIT   = 6;
  localparam int FLAG_OV_BIT  = 0;
  localparam int FLAG_UV_BIT  = 1;

  // Values after reset
  localparam logic [7:0] RST_COARSE   = 8'h00;
  localparam logic [7:0] RST_FINE     = 8'h00;
  localparam logic [7:0] RST_UV_LEVEL = 8'h00;
  localparam logic [7:0] RST_OV_LEVEL = 8'h00;
  localparam logic [7:0] RST_PERIPH   = 8'h00;
  localparam logic [7:0] RST_ABE      = 8'h00;

  // Reference and threshold steps
  localparam logic [13:0] COARSE_STEP_UV = 14'h3A98;
  localparam logic [9:0]  FINE_STEP_UV   = 10'h334;
  localparam logic [3:0]  DETECT_STEP_MV = 4'hF;

  // Peripheral control byte, bit 7 first
  typedef struct packed {
    logic diode_emulation_select;
    logic high_drive_strength;
    logic high_delay_bypass;
    logic low_delay_bypass;
    logic neg_sense_pulldown_en;
    logic pos_sense_pullup_en;
    logic undervoltage_accel_en;
    logic overvoltage_accel_en;
  } periph_ctl_t;

  // Gate driver command pair
  typedef struct packed {
    logic high_gate_drive;
    logic low_gate_drive;
  } gate_pair_t;

  // Switching cycle phases
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_HIGH,
    PH_LOW,
    PH_BOTH_LOW
  } phase_t;

endpackage

// [vreg_ctl_asserts.sv]
// Bus, set point, threshold, flag and gate checks on the bank's ports
`timescale 1ns/10ps
`default_nettype none
module vreg_ctl_asserts
  import vreg_ctl_pkg::*;
(
  // Clock, reset, bus and cycle start
  input wire logic        ref_clk_in,
  input wire logic        arst_n_in,
  input wire logic [4:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [3:0]  avs_byteenable_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic        avs_waitrequest_out,
  input wire logic        cycle_start_in,
  // Observed outputs
  input wire logic        setpoint_dac_enable_out,
  input wire logic [7:0]  coarse_code_out,
  input wire logic [4:0]  fine_code_out,
  input wire logic [21:0] vref_uv_out,
  input wire logic        overvoltage_detect_en_out,
  input wire logic        undervoltage_detect_en_out,
  input wire logic [11:0] uv_threshold_mv_out,
  input wire logic [11:0] ov_threshold_mv_out,
  input wire logic        high_gate_drive_out,
  input wire logic        low_gate_drive_out,
  input wire logic        undervoltage_flag_out,
  input wire logic        overvoltage_flag_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  logic flag_wr;
  logic flags_on;
  assign flag_wr = avs_write_in && !avs_waitrequest_out &&
                   avs_address_in == OFS_FLAGS && avs_byteenable_in[0];
  assign flags_on = undervoltage_flag_out || overvoltage_flag_out;
  sequence s_req;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_ans;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  a_one_wait: assert property (s_req |=> s_ans)
    else $error("bus answer not after one wait cycle");
  a_dac_off: assert property (!setpoint_dac_enable_out |->
    coarse_code_out == 8'h00 && fine_code_out == 5'h00 &&
    vref_uv_out == 22'h000000)
    else $error("set point live while DAC disabled");
  a_vref_sum: assert property (setpoint_dac_enable_out |->
    vref_uv_out == 22'(coarse_code_out) * 22'h003A98 +
                   22'(fine_code_out) * 22'h000334)
    else $error("reference not coarse plus fine steps");
  a_uv_ignored: assert property (!undervoltage_detect_en_out |->
    uv_threshold_mv_out == 12'h000)
    else $error("undervoltage threshold used while disabled");
  a_ov_ignored: assert property (!overvoltage_detect_en_out |->
    ov_threshold_mv_out == 12'h000)
    else $error("overvoltage threshold used while disabled");
  a_uv_sticky: assert property (undervoltage_flag_out &&
    !(flag_wr && !avs_writedata_in[FLAG_UV_BIT]) |=> undervoltage_flag_out)
    else $error("undervoltage flag dropped without clear");
  a_ov_sticky: assert property (overvoltage_flag_out &&
    !(flag_wr && !avs_writedata_in[FLAG_OV_BIT]) |=> overvoltage_flag_out)
    else $error("overvoltage flag dropped without clear");
  a_no_overlap: assert property (!(high_gate_drive_out &&
    low_gate_drive_out))
    else $error("both gate drives on together");
  a_high_waits: assert property (!high_gate_drive_out &&
    !low_gate_drive_out && !cycle_start_in && !flags_on
    |=> !high_gate_drive_out)
    else $error("high drive on before cycle start");
endmodule
bind output_regulation_control_regs vreg_ctl_asserts vreg_ctl_asserts_i (
  .ref_clk_in, .arst_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
  .avs_byteenable_in, .avs_writedata_in, .avs_waitrequest_out,
  .cycle_start_in, .setpoint_dac_enable_out, .coarse_code_out,
  .fine_code_out, .vref_uv_out, .overvoltage_detect_en_out,
  .undervoltage_detect_en_out, .uv_threshold_mv_out, .ov_threshold_mv_out,
  .high_gate_drive_out, .low_gate_drive_out, .undervoltage_flag_out,
  .overvoltage_flag_out);
`default_nettype wire

// [power_stage_model.sv]
// Power stage timing, zero detect and output comparators
`timescale 1ns/10ps
`default_nettype none
module power_stage_model (
  // Clock and reset
  input wire logic        ref_clk_in,
  input wire logic        arst_n_in,
  // Output level, thresholds and low gate drive
  input wire logic [11:0] vout_mv_in,
  input wire logic [11:0] uv_thr_in,
  input wire logic [11:0] ov_thr_in,
  input wire logic        low_drv_in,
  // Towards the bank
  output logic            below_out,
  output logic            above_out,
  output logic            zero_out,
  output logic            start_out,
  output logic            dend_out
);
  logic [4:0] ph_r;
  logic [2:0] lo_r;
  // Switching cycle of 20 clocks, on-time of 8
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      ph_r <= 5'h00;
    else
      ph_r <= (ph_r == 5'h13) ? 5'h00 : ph_r + 5'h01;
  end
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      lo_r <= 3'h0;
    else if (!low_drv_in)
      lo_r <= 3'h0;
    else if (lo_r != 3'h7)
      lo_r <= lo_r + 3'h1;
  end
  assign start_out = ph_r == 5'h13;
  assign dend_out = ph_r == 5'h07;
  assign zero_out = lo_r >= 3'h3;
  assign below_out = vout_mv_in < uv_thr_in;
  assign above_out = vout_mv_in > ov_thr_in;
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking bench for the output regulation register bank
`timescale 1ns/10ps
`default_nettype none
module tb;
  import vreg_ctl_pkg::*;
  logic ref_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [4:0] avs_address_in = 5'h00;
  logic [3:0] avs_byteenable_in = 4'hF;
  logic [31:0] avs_writedata_in = 32'h00000000;
  logic [11:0] vout_mv = 12'h2BC;
  wire logic [31:0] avs_readdata_out;
  wire logic [21:0] vref_uv_out;
  wire logic [11:0] uv_threshold_mv_out, ov_threshold_mv_out;
  wire logic [7:0] coarse_code_out;
  wire logic [4:0] fine_code_out;
  wire logic avs_waitrequest_out, vout_below_uv_in, vout_above_ov_in;
  wire logic low_side_zero_in, cycle_start_in, duty_end_in;
  wire logic setpoint_dac_enable_out, overvoltage_detect_en_out;
  wire logic undervoltage_detect_en_out, high_gate_drive_out;
  wire logic low_gate_drive_out, high_drive_1a_out, high_dead_time_add_out;
  wire logic low_dead_time_add_out, pos_sense_pullup_out;
  wire logic neg_sense_pulldown_out, undervoltage_flag_out;
  wire logic overvoltage_flag_out;
  int n_mismatch = 0;
  int comparisons = 0;
  int nb;
  int non;
  always #25 ref_clk_in = ~ref_clk_in;
  output_regulation_control_regs output_regulation_control_regs_i (
    .ref_clk_in, .arst_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_byteenable_in, .avs_writedata_in, .avs_readdata_out,
    .avs_waitrequest_out, .vout_below_uv_in, .vout_above_ov_in,
    .low_side_zero_in, .cycle_start_in, .duty_end_in,
    .setpoint_dac_enable_out, .coarse_code_out, .fine_code_out, .vref_uv_out,
    .overvoltage_detect_en_out, .undervoltage_detect_en_out,
    .uv_threshold_mv_out, .ov_threshold_mv_out, .high_gate_drive_out,
    .low_gate_drive_out, .high_drive_1a_out, .high_dead_time_add_out,
    .low_dead_time_add_out, .pos_sense_pullup_out, .neg_sense_pulldown_out,
    .undervoltage_flag_out, .overvoltage_flag_out);
  power_stage_model power_stage_model_i (
    .ref_clk_in, .arst_n_in, .vout_mv_in(vout_mv),
    .uv_thr_in(uv_threshold_mv_out), .ov_thr_in(ov_threshold_mv_out),
    .low_drv_in(low_gate_drive_out), .below_out(vout_below_uv_in),
    .above_out(vout_above_ov_in), .zero_out(low_side_zero_in),
    .start_out(cycle_start_in), .dend_out(duty_end_in));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  // One Avalon transfer, held until waitrequest is seen low; a hang is
  // left to the watchdog so the request never drops early
  task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge ref_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= {24'h000000, d};
    avs_write_in <= w;
    avs_read_in <= !w;
    do begin
      @(posedge ref_clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 8'h00, q);
    chk(q, e);
  endtask
  // Counts cycles with both drives off and with any drive on
  task automatic watch();
    nb = 0;
    non = 0;
    repeat (60) begin
      @(posedge ref_clk_in);
      if ({high_gate_drive_out, low_gate_drive_out} === 2'b00)
        nb++;
      else
        non++;
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    cyc(6);
    arst_n_in <= 1'b1;
    chk({high_dead_time_add_out, low_dead_time_add_out}, 2'h3);
    for (int i = 0; i < 8; i++)
      rd(5'(i * 4), 32'h00000000);
    $display("test reset done");
    wr(OFS_FINE, 8'hFF);
    wr(OFS_COARSE, 8'hC8);
    rd(OFS_FINE, 32'h0000009F);
    chk({setpoint_dac_enable_out, fine_code_out}, 6'h3F);
    chk(coarse_code_out, 8'hC8);
    chk(vref_uv_out, 22'h0000C8 * 22'h003A98 + 22'h1F * 22'h334);
    avs_byteenable_in <= 4'h0;
    wr(OFS_COARSE, 8'h11);
    avs_byteenable_in <= 4'hF;
    rd(OFS_COARSE, 32'h000000C8);
    wr(OFS_FINE, 8'h1F);
    cyc(2);
    chk({coarse_code_out, vref_uv_out}, 30'h0);
    $display("test set point done");
    wr(OFS_PERIPH, 8'h6C);
    rd(OFS_PERIPH, 32'h0000006C);
    chk({high_drive_1a_out, high_dead_time_add_out, low_dead_time_add_out,
         neg_sense_pulldown_out, pos_sense_pullup_out}, 5'h17);
    wr(OFS_PERIPH, 8'h10);
    cyc(2);
    chk({high_drive_1a_out, high_dead_time_add_out, low_dead_time_add_out,
         neg_sense_pulldown_out, pos_sense_pullup_out}, 5'h08);
    cyc(25);
    watch();
    chk(32'(nb), 32'h0);
    wr(OFS_PERIPH, 8'h80);
    cyc(25);
    watch();
    chk(32'(nb > 0), 32'h1);
    $display("test control done");
    wr(OFS_UV_LEVEL, 8'h20);
    wr(OFS_OV_LEVEL, 8'h40);
    wr(OFS_ABE, 8'hC0);
    cyc(8);
    wr(OFS_FLAGS, 8'h00);
    chk(uv_threshold_mv_out, 12'h020 * 12'h00F);
    chk(ov_threshold_mv_out, 12'h040 * 12'h00F);
    chk({overvoltage_detect_en_out, undervoltage_detect_en_out}, 2'h3);
    vout_mv <= 12'h190;
    cyc(8);
    chk({undervoltage_flag_out, overvoltage_flag_out}, 2'h2);
    vout_mv <= 12'h2BC;
    cyc(8);
    chk(undervoltage_flag_out, 1'b1);
    wr(OFS_FLAGS, 8'h01);
    rd(OFS_FLAGS, 32'h00000000);
    vout_mv <= 12'h3E8;
    cyc(8);
    rd(OFS_FLAGS, 32'h00000001);
    watch();
    chk(32'(non > 0), 32'h1);
    wr(OFS_FLAGS, 8'h00);
    rd(OFS_FLAGS, 32'h00000001);
    vout_mv <= 12'h2BC;
    cyc(8);
    wr(OFS_FLAGS, 8'h00);
    rd(OFS_FLAGS, 32'h00000000);
    $display("test flags done");
    wr(OFS_PERIPH, 8'h03);
    for (int i = 0; i < 2; i++) begin
      vout_mv <= i ? 12'h190 : 12'h3E8;
      cyc(8);
      watch();
      chk(32'(non), 32'h0);
      vout_mv <= 12'h2BC;
      cyc(8);
    end
    wr(OFS_FLAGS, 8'h00);
    $display("test accelerators done");
    wr(OFS_ABE, 8'h00);
    cyc(2);
    chk({uv_threshold_mv_out, ov_threshold_mv_out}, 24'h0);
    vout_mv <= 12'h3E8;
    cyc(8);
    rd(OFS_FLAGS, 32'h00000000);
    watch();
    chk(32'(non > 0), 32'h1);
    $display("test detectors off done");
    wrap_up();
  end
endmodule
`default_nettype wire
